// ==== design/fcsm_defines.svh ====
`ifndef FCSM_DEFINES_SVH
`define FCSM_DEFINES_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_READ_ARRAY 8'hff
`define CMD_PGM_SETUP 8'h40
`define CMD_PGM_SETUP_ALT 8'h10
`define CMD_BP_SETUP 8'he8
`define CMD_ERS_SETUP 8'h20
`define CMD_BUFFERED_FACTORY_PROGRAM_SETUP 8'h80
`define CMD_CONFIRM 8'hd0
`define CMD_SUSPEND 8'hb0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ID 8'h90
`define CMD_QUERY 8'h98
`define CMD_LOCK_SETUP 8'h60
`define CMD_LOCK_BLOCK 8'h01
`define CMD_LOCK_DOWN 8'h2f
`define CMD_CONFIG_SET 8'h03

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_MODES 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10

// ----------------------------------------
// status word bits, error groups, irq bits
// ----------------------------------------
`define SW_READY 7
`define SW_ERS_SUSP 6
`define SW_ERS_ERR 5
`define SW_PGM_ERR 4
`define SW_VPP_ERR 3
`define SW_PGM_SUSP 2
`define SW_LOCK_ERR 1
`define SW_PART 0
`define SW_RESET 8'h80
`define ERR_SEQ 4'hc
`define IRQ_DONE 0
`define IRQ_SEQ 1
`define IRQ_SUSP 2
`define IRQ_RESET 3'h0
`define PARAM_PART 2'h0

`endif

// ==== design/fcsm_pkg.sv ====
package fcsm_pkg;

  typedef enum logic [4:0] {
    ST_READY = 5'h00, ST_LOCK_SETUP = 5'h01, ST_BUFFERED_FACTORY_PROGRAM_SETUP = 5'h02, ST_PGM_SETUP = 5'h03,
    ST_PGM_BUSY = 5'h04, ST_PGM_SUSP = 5'h05, ST_BP_SETUP = 5'h06, ST_BP_LOAD1 = 5'h07,
    ST_BP_LOAD2 = 5'h08, ST_BP_CONFIRM = 5'h09, ST_BP_BUSY = 5'h0a, ST_BP_SUSP = 5'h0b,
    ST_ERS_SETUP = 5'h0c, ST_ERS_BUSY = 5'h0d, ST_ERS_SUSP = 5'h0e, ST_PGM_SETUP_ES = 5'h0f,
    ST_PGM_BUSY_ES = 5'h10, ST_LOCK_SETUP_ES = 5'h11
  } chip_state_type;

  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0, MODE_ID = 2'h1, MODE_QUERY = 2'h2, MODE_STATUS = 2'h3
  } read_mode_type;

  typedef struct packed {
    logic ers_err;
    logic pgm_err;
    logic vpp_err;
    logic lock_err;
  } status_state_type;

  typedef struct packed {
    read_mode_type [3:0] mode;
  } mode_state_type;

  typedef struct packed {
    chip_state_type chip;
    logic [1:0] op_part;
    logic [1:0] cmd_part;
    logic [4:0] buf_left;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
  } main_state_type;

endpackage : fcsm_pkg

// ==== design/status_word_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fcsm_defines.svh"
module status_word_unit
  import fcsm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // sticky error control
  input wire logic i_clear,
  input wire logic [3:0] i_err_set,
  // live machine state
  input wire logic i_busy,
  input wire logic i_ers_susp,
  input wire logic i_pgm_susp,
  input wire logic i_other_part,
  // composed word
  output logic [7:0] o_status_word
);

  status_state_type st_ff;
  status_state_type nxt_st;

  // clear first, then set, so a set in the same cycle wins
  always_comb
  begin
    nxt_st = st_ff;
    if (i_clear)
    begin
      nxt_st = '0;
    end
    nxt_st = nxt_st | i_err_set;
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      st_ff <= '0;
    else if (i_clk_en)
      st_ff <= nxt_st;
  end

  // compose live and sticky bits
  always_comb
  begin
    o_status_word = `SW_RESET;
    o_status_word[`SW_READY] = !i_busy;
    o_status_word[`SW_ERS_SUSP] = i_ers_susp;
    o_status_word[`SW_ERS_ERR] = st_ff.ers_err;
    o_status_word[`SW_PGM_ERR] = st_ff.pgm_err;
    o_status_word[`SW_VPP_ERR] = st_ff.vpp_err;
    o_status_word[`SW_PGM_SUSP] = i_pgm_susp;
    o_status_word[`SW_LOCK_ERR] = st_ff.lock_err;
    o_status_word[`SW_PART] = i_busy && i_other_part;
  end

  property p_sticky_err;
    @(posedge i_clock) disable iff (i_rst)
    o_status_word[`SW_PGM_ERR] && !(i_clear && i_clk_en) |=> o_status_word[`SW_PGM_ERR];
  endproperty
  a_sticky_err: assert property (p_sticky_err) else $error("error bit dropped without clear");

endmodule : status_word_unit
`default_nettype wire

// ==== design/partition_read_mode.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fcsm_defines.svh"
module partition_read_mode
  import fcsm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // interpreted command
  input wire logic i_cmd_taken,
  input wire logic [7:0] i_cmd_code,
  input wire logic [1:0] i_cmd_part,
  // array activity
  input wire logic i_busy,
  input wire logic [1:0] i_op_part,
  // per-partition outputs
  output logic [7:0] o_read_modes,
  output logic [3:0] o_query_ok
);

  mode_state_type st_ff;
  mode_state_type nxt_st;

  // only the addressed partition changes; others keep their mode
  always_comb
  begin
    nxt_st = st_ff;
    if (i_cmd_taken)
    begin
      unique case (i_cmd_code)
        `CMD_READ_ARRAY: nxt_st.mode[i_cmd_part] = MODE_ARRAY;
        `CMD_READ_ID: nxt_st.mode[i_cmd_part] = MODE_ID;
        `CMD_QUERY: nxt_st.mode[i_cmd_part] = MODE_QUERY;
        `CMD_READ_STATUS, `CMD_PGM_SETUP, `CMD_PGM_SETUP_ALT, `CMD_BP_SETUP,
        `CMD_ERS_SETUP, `CMD_BUFFERED_FACTORY_PROGRAM_SETUP, `CMD_LOCK_SETUP: nxt_st.mode[i_cmd_part] = MODE_STATUS;
        default: nxt_st = st_ff;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      st_ff <= '0;
    else if (i_clk_en)
      st_ff <= nxt_st;
  end

  assign o_read_modes = st_ff;

  // query data blocked while the parameter partition is busy
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_query
      assign o_query_ok[p] = (st_ff.mode[p] == MODE_QUERY) && !(i_busy && i_op_part == `PARAM_PART);
    end
  endgenerate

  property p_query_mode;
    @(posedge i_clock) disable iff (i_rst)
    i_cmd_taken && i_cmd_code == `CMD_QUERY |=> st_ff.mode[$past(i_cmd_part)] == MODE_QUERY;
  endproperty
  a_query_mode: assert property (p_query_mode) else $error("query mode not entered");

  property p_mode_hold;
    @(posedge i_clock) disable iff (i_rst)
    !i_cmd_taken |=> $stable(o_read_modes);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("read mode changed without command");

endmodule : partition_read_mode
`default_nettype wire

// ==== design/flash_command_state_machine.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fcsm_defines.svh"
module flash_command_state_machine
  import fcsm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // array engine
  output logic o_array_run,
  output logic [1:0] o_array_kind,
  output logic [1:0] o_array_part,
  input wire logic i_array_done,
  input wire logic i_array_fail,
  input wire logic i_array_vpp_low,
  input wire logic i_array_locked,
  // partition read side
  output logic [7:0] o_read_modes,
  output logic [3:0] o_query_ok,
  output logic [7:0] o_status_word,
  // interrupt
  output logic o_irq
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_busy(input chip_state_type s);
    return s inside {ST_PGM_BUSY, ST_BP_BUSY, ST_ERS_BUSY, ST_PGM_BUSY_ES};
  endfunction : is_busy

  function automatic logic is_cmd_state(input chip_state_type s);
    return s inside {ST_READY, ST_PGM_BUSY, ST_PGM_SUSP, ST_BP_BUSY, ST_BP_SUSP,
                     ST_ERS_BUSY, ST_ERS_SUSP, ST_PGM_BUSY_ES};
  endfunction : is_cmd_state

  main_state_type st_ff;
  main_state_type nxt_st;
  logic wb_req;
  logic cmd_pulse;
  logic [7:0] cmd_code;
  logic [1:0] cmd_part;
  logic [3:0] err_set;
  logic [2:0] ev;
  logic clr_sw;
  logic busy;
  logic ers_susp;
  logic pgm_susp;

  // bus request and command cycle strobe
  assign wb_req = i_wb_cyc && i_wb_stb && !st_ff.ack;
  assign cmd_pulse = wb_req && i_wb_we && i_wb_adr == `REG_CMD && i_wb_sel[0] && i_clk_en;
  assign cmd_code = i_wb_dat[7:0];
  assign cmd_part = i_wb_dat[9:8];
  assign busy = is_busy(st_ff.chip);
  assign ers_susp = st_ff.chip inside {ST_ERS_SUSP, ST_PGM_SETUP_ES, ST_PGM_BUSY_ES, ST_LOCK_SETUP_ES};
  assign pgm_susp = st_ff.chip inside {ST_PGM_SUSP, ST_BP_SUSP};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    err_set = 4'h0;
    ev = 3'h0;
    clr_sw = 1'b0;
    nxt_st.ack = i_wb_cyc && i_wb_stb && !st_ff.ack;
    // chip state from present state and command code only
    if (cmd_pulse)
    begin
      nxt_st.cmd_part = cmd_part;
      if (is_cmd_state(st_ff.chip) && cmd_code == `CMD_CLEAR_STATUS)
        clr_sw = 1'b1;
      unique case (st_ff.chip)
        ST_READY:
        begin
          unique case (cmd_code)
            `CMD_PGM_SETUP, `CMD_PGM_SETUP_ALT: nxt_st.chip = ST_PGM_SETUP;
            `CMD_BP_SETUP: nxt_st.chip = ST_BP_SETUP;
            `CMD_ERS_SETUP: nxt_st.chip = ST_ERS_SETUP;
            `CMD_BUFFERED_FACTORY_PROGRAM_SETUP: nxt_st.chip = ST_BUFFERED_FACTORY_PROGRAM_SETUP;
            `CMD_LOCK_SETUP: nxt_st.chip = ST_LOCK_SETUP;
            default: nxt_st.chip = ST_READY;
          endcase
          nxt_st.op_part = cmd_part;
        end
        ST_LOCK_SETUP, ST_LOCK_SETUP_ES:
        begin
          nxt_st.chip = (st_ff.chip == ST_LOCK_SETUP) ? ST_READY : ST_ERS_SUSP;
          if (!(cmd_code inside {`CMD_LOCK_BLOCK, `CMD_CONFIRM, `CMD_LOCK_DOWN, `CMD_CONFIG_SET}))
          begin
            err_set = `ERR_SEQ;
            ev[`IRQ_SEQ] = 1'b1;
          end
        end
        ST_BUFFERED_FACTORY_PROGRAM_SETUP, ST_ERS_SETUP, ST_BP_CONFIRM:
        begin
          if (cmd_code == `CMD_CONFIRM)
            nxt_st.chip = (st_ff.chip == ST_ERS_SETUP) ? ST_ERS_BUSY :
                          (st_ff.chip == ST_BP_CONFIRM) ? ST_BP_BUSY : ST_READY;
          else
          begin
            nxt_st.chip = ST_READY;
            err_set = `ERR_SEQ;
            ev[`IRQ_SEQ] = 1'b1;
          end
        end
        ST_PGM_SETUP: nxt_st.chip = ST_PGM_BUSY;
        ST_PGM_SETUP_ES: nxt_st.chip = ST_PGM_BUSY_ES;
        ST_BP_SETUP:
        begin
          nxt_st.chip = ST_BP_LOAD1;
          nxt_st.buf_left = i_wb_dat[4:0];
        end
        ST_BP_LOAD1: nxt_st.chip = ST_BP_LOAD2;
        ST_BP_LOAD2:
        begin
          if (st_ff.buf_left != 5'h00)
            nxt_st.buf_left = st_ff.buf_left - 5'h01;
        end
        ST_PGM_BUSY, ST_BP_BUSY, ST_ERS_BUSY:
        begin
          if (cmd_code == `CMD_SUSPEND)
          begin
            nxt_st.chip = (st_ff.chip == ST_PGM_BUSY) ? ST_PGM_SUSP :
                          (st_ff.chip == ST_BP_BUSY) ? ST_BP_SUSP : ST_ERS_SUSP;
            ev[`IRQ_SUSP] = 1'b1;
          end
        end
        ST_PGM_SUSP, ST_BP_SUSP:
        begin
          if (cmd_code == `CMD_CONFIRM)
            nxt_st.chip = (st_ff.chip == ST_PGM_SUSP) ? ST_PGM_BUSY : ST_BP_BUSY;
        end
        ST_ERS_SUSP:
        begin
          unique case (cmd_code)
            `CMD_CONFIRM: nxt_st.chip = ST_ERS_BUSY;
            `CMD_PGM_SETUP, `CMD_PGM_SETUP_ALT: nxt_st.chip = ST_PGM_SETUP_ES;
            `CMD_LOCK_SETUP: nxt_st.chip = ST_LOCK_SETUP_ES;
            `CMD_ERS_SETUP, `CMD_BP_SETUP, `CMD_BUFFERED_FACTORY_PROGRAM_SETUP:
            begin
              err_set = `ERR_SEQ;
              ev[`IRQ_SEQ] = 1'b1;
            end
            default: nxt_st.chip = ST_ERS_SUSP;
          endcase
        end
        ST_PGM_BUSY_ES: nxt_st.chip = ST_PGM_BUSY_ES;
        default: nxt_st.chip = ST_READY;
      endcase
    end
    // buffer fully loaded: move on to confirm one clock later, without a bus write
    if (st_ff.chip == ST_BP_LOAD2 && st_ff.buf_left == 5'h00 && i_clk_en)
      nxt_st.chip = ST_BP_CONFIRM;
    // array completion, wins over a same-cycle suspend
    if (i_array_done && busy)
    begin
      nxt_st.chip = (st_ff.chip == ST_PGM_BUSY_ES) ? ST_ERS_SUSP : ST_READY;
      err_set = err_set | {i_array_fail && st_ff.chip == ST_ERS_BUSY,
                           i_array_fail && st_ff.chip != ST_ERS_BUSY, i_array_vpp_low, i_array_locked};
      ev[`IRQ_DONE] = 1'b1;
    end
    // read data and read-to-clear irq status
    if (wb_req && !i_wb_we)
    begin
      unique case (i_wb_adr)
        `REG_STATUS: nxt_st.rdat = {19'h00000, st_ff.chip, o_status_word};
        `REG_MODES: nxt_st.rdat = {18'h00000, st_ff.op_part, o_query_ok, o_read_modes};
        `REG_IRQ_STAT: nxt_st.rdat = {29'h00000000, st_ff.irq_stat};
        `REG_IRQ_MASK: nxt_st.rdat = {29'h00000000, st_ff.irq_mask};
        `REG_CMD: nxt_st.rdat = {22'h000000, st_ff.cmd_part, 8'h00};
        default: nxt_st.rdat = 32'h00000000;
      endcase
      if (i_wb_adr == `REG_IRQ_STAT)
        nxt_st.irq_stat = 3'h0;
    end
    if (wb_req && i_wb_we && i_wb_adr == `REG_IRQ_MASK && i_wb_sel[0])
      nxt_st.irq_mask = i_wb_dat[2:0];
    // new events set after the clear
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.irq_stat <= `IRQ_RESET;
    end
    else if (i_clk_en)
      st_ff <= nxt_st;
  end

  // outputs
  assign o_wb_ack = st_ff.ack;
  assign o_wb_dat = st_ff.rdat;
  assign o_array_run = busy;
  assign o_array_part = st_ff.op_part;
  assign o_array_kind = st_ff.chip inside {ST_ERS_BUSY, ST_ERS_SUSP} ? 2'h3 :
                        st_ff.chip inside {ST_BP_BUSY, ST_BP_SUSP} ? 2'h2 : 2'h1;
  assign o_irq = |(st_ff.irq_stat & st_ff.irq_mask);

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  status_word_unit u_status (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_clear(clr_sw),
    .i_err_set(err_set),
    .i_busy(busy),
    .i_ers_susp(ers_susp),
    .i_pgm_susp(pgm_susp),
    .i_other_part(st_ff.cmd_part != st_ff.op_part),
    .o_status_word(o_status_word)
  );

  partition_read_mode u_modes (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_cmd_taken(cmd_pulse && is_cmd_state(st_ff.chip)),
    .i_cmd_code(cmd_code),
    .i_cmd_part(cmd_part),
    .i_busy(busy),
    .i_op_part(st_ff.op_part),
    .o_read_modes(o_read_modes),
    .o_query_ok(o_query_ok)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_ready_bit;
    @(posedge i_clock) disable iff (i_rst)
    o_status_word[`SW_READY] == !o_array_run;
  endproperty
  a_ready_bit: assert property (p_ready_bit) else $error("ready bit disagrees with busy");

  property p_bad_erase_confirm;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_ERS_SETUP && cmd_code != `CMD_CONFIRM
    |=> st_ff.chip == ST_READY && o_status_word[`SW_ERS_ERR] && o_status_word[`SW_PGM_ERR];
  endproperty
  a_bad_erase_confirm: assert property (p_bad_erase_confirm) else $error("bad erase confirm not flagged");

  property p_erase_suspend;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_ERS_BUSY && cmd_code == `CMD_SUSPEND && !i_array_done
    |=> st_ff.chip == ST_ERS_SUSP ##0 o_status_word[`SW_ERS_SUSP];
  endproperty
  a_erase_suspend: assert property (p_erase_suspend) else $error("erase suspend not entered");

  property p_erase_resume;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_ERS_SUSP && cmd_code == `CMD_CONFIRM |=> o_array_run && o_array_kind == 2'h3;
  endproperty
  a_erase_resume: assert property (p_erase_resume) else $error("erase not resumed");

  // bus writes are never in adjacent cycles, so each step is checked on its own
  property p_bp_steps;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_BP_LOAD1 |=> st_ff.chip == ST_BP_LOAD2;
  endproperty
  a_bp_steps: assert property (p_bp_steps) else $error("buffered load steps wrong");

  property p_bp_setup;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_BP_SETUP |=> st_ff.chip == ST_BP_LOAD1;
  endproperty
  a_bp_setup: assert property (p_bp_setup) else $error("buffered setup did not load");

  property p_nested_program;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_ERS_SUSP && cmd_code == `CMD_PGM_SETUP
    |=> st_ff.chip == ST_PGM_SETUP_ES && o_status_word[`SW_ERS_SUSP];
  endproperty
  a_nested_program: assert property (p_nested_program) else $error("nested program setup missed");

  property p_suspend_seq_err;
    @(posedge i_clock) disable iff (i_rst)
    cmd_pulse && st_ff.chip == ST_ERS_SUSP && cmd_code == `CMD_ERS_SETUP
    |=> o_status_word[`SW_READY] && o_status_word[`SW_ERS_ERR] && o_status_word[`SW_PGM_ERR];
  endproperty
  a_suspend_seq_err: assert property (p_suspend_seq_err) else $error("suspend sequence error not shown");

  property p_single_op;
    @(posedge i_clock) disable iff (i_rst)
    o_array_run && $past(o_array_run) |-> $stable(o_array_part);
  endproperty
  a_single_op: assert property (p_single_op) else $error("active partition changed mid operation");

endmodule : flash_command_state_machine
`default_nettype wire

// ==== sim/array_engine_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module array_engine_model #(parameter int delay_cycles = 4)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // operation request from the block
  input wire logic i_run,
  // bench controls
  input wire logic i_hold,
  input wire logic i_fail,
  input wire logic i_vpp_low,
  input wire logic i_locked,
  // completion and error flags
  output logic o_done,
  output logic o_fail,
  output logic o_vpp_low,
  output logic o_locked
);
  logic [7:0] cnt_ff;

  // ----------------------------------------
  // array timing
  // ----------------------------------------
  // one pulse after a fixed run time; flags only beside the pulse
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff <= 8'h00;
      o_done <= 1'b0;
      {o_fail, o_vpp_low, o_locked} <= 3'h0;
    end
    else if (i_run && !i_hold && !o_done && cnt_ff == 8'(delay_cycles))
    begin
      cnt_ff <= 8'h00;
      o_done <= 1'b1;
      {o_fail, o_vpp_low, o_locked} <= {i_fail, i_vpp_low, i_locked};
    end
    else
    begin
      o_done <= 1'b0;
      {o_fail, o_vpp_low, o_locked} <= 3'h0;
      cnt_ff <= (i_run && !i_hold) ? cnt_ff + 8'h01 : (i_run ? cnt_ff : 8'h00);
    end
  end
endmodule : array_engine_model
`default_nettype wire

// ==== sim/test_flash_command_state_machine.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_flash_command_state_machine;
  logic clock, rst, cyc, stb, we, hold, fail, run, done, a_fail, a_vpp, a_lock, ack, irq, vpp, lck;
  logic [7:0] adr, modes, sw;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel, qok;
  logic [1:0] kind, part;
  logic [7:0] codes [4] = '{8'hff, 8'h90, 8'h98, 8'h70};
  int fail_count, num_checks;

  flash_command_state_machine i_dut (.i_clock(clock), .i_rst(rst), .i_clk_en(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_array_run(run), .o_array_kind(kind), .o_array_part(part), .i_array_done(done),
    .i_array_fail(a_fail), .i_array_vpp_low(a_vpp), .i_array_locked(a_lock), .o_read_modes(modes),
    .o_query_ok(qok), .o_status_word(sw), .o_irq(irq));
  array_engine_model i_eng (.i_clock(clock), .i_rst(rst), .i_run(run), .i_hold(hold), .i_fail(fail),
    .i_vpp_low(vpp), .i_locked(lck), .o_done(done), .o_fail(a_fail), .o_vpp_low(a_vpp), .o_locked(a_lock));

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // the tests need a few thousand cycles at most
  initial
  begin
    #100000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // one classic cycle, held until ack is sampled high
  task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50)
    begin
      fail_count++;
      $display("Error at %0t: no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_xfer

  task cmd(input logic [1:0] p, input logic [7:0] c);
    wb_xfer(1'b1, 8'h00, {22'h0, p, c});
  endtask : cmd

  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0);
    check_val(q & mask, exp);
  endtask : rd_chk

  task st(input logic [4:0] s, input logic [7:0] w);
    rd_chk(8'h04, 32'h1fff, {19'h0, s, w});
  endtask : st

  task wait_idle();
    int n;
    n = 0;
    while (run !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
  endtask : wait_idle

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {cyc, stb, we, hold, fail, vpp, lck} = 7'h0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    rst = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // reset values, unmapped place
    st(5'h00, 8'h80);
    rd_chk(8'h08, 32'hffffffff, 32'h0);
    rd_chk(8'h10, 32'h7, 32'h0);
    rd_chk(8'h14, 32'hffffffff, 32'h0);
    // ack stands one cycle only
    @(posedge clock);
    check_val({31'h0, ack}, 32'h0);
    check_val({31'h0, irq}, 32'h0);
    check_val({16'h0, modes, sw}, 32'h0080);
    // erase, query in background, suspend and nested program
    hold <= 1'b1;
    cmd(2'h1, 8'h20);
    cmd(2'h1, 8'hd0);
    check_val({28'h0, run, kind, 1'b0}, 32'h0000000e);
    cmd(2'h2, 8'h98);
    st(5'h0d, 8'h01);
    rd_chk(8'h08, 32'h30, 32'h20);
    cmd(2'h3, 8'h40);
    rd_chk(8'h04, 32'h1f00, 32'h0d00);
    check_val({30'h0, part}, 32'h1);
    cmd(2'h1, 8'hb0);
    st(5'h0e, 8'hc0);
    cmd(2'h1, 8'h40);
    rd_chk(8'h04, 32'h1f00, 32'h0f00);
    cmd(2'h1, 8'h34);
    rd_chk(8'h04, 32'h1f00, 32'h1000);
    hold <= 1'b0;
    wait_idle();
    rd_chk(8'h04, 32'h1f00, 32'h0e00);
    hold <= 1'b1;
    cmd(2'h1, 8'h20);
    st(5'h0e, 8'hf0);
    cmd(2'h1, 8'h50);
    st(5'h0e, 8'hc0);
    cmd(2'h1, 8'hd0);
    st(5'h0d, 8'h00);
    hold <= 1'b0;
    wait_idle();
    st(5'h00, 8'h80);
    rd_chk(8'h08, 32'h30, 32'h20);
    // every read mode on one partition
    for (int i = 0; i < 4; i++)
    begin
      cmd(2'h3, codes[i]);
      rd_chk(8'h08, 32'hc0, 32'(i) << 6);
    end
    // query on the busy parameter partition
    hold <= 1'b1;
    cmd(2'h0, 8'h20);
    cmd(2'h0, 8'hd0);
    cmd(2'h0, 8'h98);
    check_val({28'h0, qok}, 32'h0);
    rd_chk(8'h08, 32'h3, 32'h2);
    hold <= 1'b0;
    wait_idle();
    check_val({28'h0, qok}, 32'h5);
    // buffered program: wrong confirm, then failing run
    for (int k = 0; k < 2; k++)
    begin
      hold <= 1'b1;
      fail <= 1'(k);
      cmd(2'h2, 8'he8);
      rd_chk(8'h04, 32'h1f00, 32'h0600);
      cmd(2'h2, 8'h02);
      rd_chk(8'h04, 32'h1f00, 32'h0700);
      cmd(2'h2, 8'haa);
      rd_chk(8'h04, 32'h1f00, 32'h0800);
      cmd(2'h2, 8'hbb);
      rd_chk(8'h04, 32'h1f00, 32'h0800);
      cmd(2'h2, 8'hcc);
      rd_chk(8'h04, 32'h1f00, 32'h0900);
      cmd(2'h2, (k == 0) ? 8'hff : 8'hd0);
      if (k == 0)
        st(5'h00, 8'hb0);
      else
        check_val({29'h0, run, kind}, 32'h6);
      hold <= 1'b0;
      wait_idle();
      if (k == 0)
        cmd(2'h2, 8'h50);
    end
    fail <= 1'b0;
    st(5'h00, 8'h90);
    // word program ending with supply and lock flags
    {vpp, lck} <= 2'b11;
    cmd(2'h2, 8'h40);
    cmd(2'h2, 8'h12);
    wait_idle();
    {vpp, lck} <= 2'b00;
    st(5'h00, 8'h9a);
    cmd(2'h2, 8'h50);
    st(5'h00, 8'h80);
    // lock setup, then program suspend and resume
    cmd(2'h1, 8'h60);
    cmd(2'h1, 8'h01);
    st(5'h00, 8'h80);
    hold <= 1'b1;
    cmd(2'h1, 8'h10);
    cmd(2'h1, 8'h55);
    cmd(2'h1, 8'hb0);
    st(5'h05, 8'h84);
    cmd(2'h1, 8'hd0);
    st(5'h04, 8'h00);
    hold <= 1'b0;
    wait_idle();
    st(5'h00, 8'h80);
    // erase setup refused
    cmd(2'h0, 8'h20);
    cmd(2'h0, 8'h70);
    st(5'h00, 8'hb0);
    cmd(2'h0, 8'h50);
    // interrupt raise, clear, mask
    wb_xfer(1'b1, 8'h10, 32'h7);
    rd_chk(8'h10, 32'h7, 32'h7);
    wb_xfer(1'b0, 8'h0c, 32'h0);
    cmd(2'h1, 8'h20);
    cmd(2'h1, 8'hd0);
    wait_idle();
    check_val({31'h0, irq}, 32'h1);
    rd_chk(8'h0c, 32'h7, 32'h1);
    check_val({31'h0, irq}, 32'h0);
    wb_xfer(1'b1, 8'h10, 32'h1);
    cmd(2'h1, 8'h20);
    cmd(2'h1, 8'h70);
    check_val({31'h0, irq}, 32'h0);
    rd_chk(8'h0c, 32'h7, 32'h2);
    end_sim();
  end
endmodule : test_flash_command_state_machine
`default_nettype wire
